// File: rtl/urx_pkg.sv
// Shared constants and types for the UART receive status and interrupt block.
package urx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL1  = 8'h04;
  localparam logic [7:0] ADDR_CTRL2  = 8'h08;
  localparam logic [7:0] ADDR_DATA   = 8'h0C;
  localparam logic [7:0] ADDR_BAUD   = 8'h10;
  localparam logic [7:0] ADDR_INTC   = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Status register bit positions.
  localparam int ST_PERR = 0;
  localparam int ST_FERR = 1;
  localparam int ST_OVR  = 2;
  localparam int ST_RXA  = 3;
  localparam int ST_TXI  = 4;
  localparam int ST_TXE  = 5;
  localparam int ST_RXI  = 6;

  // Control one bit positions; bit 0 is the read-only ninth data bit.
  localparam int C1_RX8  = 0;
  localparam int C1_ODD  = 3;
  localparam int C1_PEN  = 4;
  localparam int C1_NINE = 5;
  localparam int C1_UEN  = 6;
  localparam int C1_MODE = 7;
  localparam logic [7:0] C1_WMASK = 8'hF8;

  // Control two bit positions.
  localparam int C2_RIE  = 1;
  localparam int C2_TIIE = 2;
  localparam int C2_TEIE = 3;
  localparam int C2_WAKE = 4;
  localparam int C2_ADEN = 5;
  localparam int C2_RXEN = 6;

  // Interrupt control bit positions.
  localparam int IC_GIE  = 0;
  localparam int IC_MIE  = 1;
  localparam int IC_FLAG = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and timing.
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [2:0] RX_SYNC_IDLE  = 3'h7;
  localparam int         CLK_PERIOD_NS = 50;
  localparam int         STARTUP_NS    = 51200;

  // One received word with its error flags.
  typedef struct packed {
    logic       perr;
    logic       ferr;
    logic [8:0] data;
  } urx_word_t;

  // Wake-up sequencer states.
  typedef enum logic [2:0] {
    WK_RUN   = 3'b001,
    WK_SLEEP = 3'b010,
    WK_START = 3'b100
  } urx_wake_t;

endpackage : urx_pkg

// File: rtl/urx_buf_if.sv
// Connection between the register logic and the receive word buffer.
`timescale 1ns/1ns
interface urx_buf_if;
  logic              push;
  urx_pkg::urx_word_t push_word;
  logic              pop;
  urx_pkg::urx_word_t head;
  logic              full;
  logic              empty;
  logic              overrun_p;

  modport owner  (output push, push_word, pop, input head, full, empty, overrun_p);
  modport buffer (input push, push_word, pop, output head, full, empty, overrun_p);
endinterface : urx_buf_if

// File: rtl/urx_buf.sv
// Two-entry receive word buffer with overrun detection.
`timescale 1ns/1ns
module urx_buf #(
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // Buffer port.
  urx_buf_if.buffer   bif
);
  localparam int IW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2) begin : g_chk
    $error("urx_buf needs DEPTH of at least 2");
  end

  typedef struct packed {
    urx_pkg::urx_word_t [DEPTH-1:0] mem;
    logic [IW-1:0]                  rd;
    logic [IW-1:0]                  wr;
    logic [CW-1:0]                  cnt;
  } urx_buf_state_t;

  urx_buf_state_t q;
  urx_buf_state_t d;
  logic           do_push;
  logic           do_pop;

  function automatic logic [IW-1:0] nxt(input logic [IW-1:0] p);
    nxt = (p == IW'(DEPTH - 1)) ? '0 : IW'(p + 1'b1);
  endfunction : nxt

  assign bif.full      = (q.cnt == CW'(DEPTH));
  assign bif.empty     = (q.cnt == '0);
  assign bif.head      = q.mem[q.rd];
  assign do_pop        = bif.pop & ~bif.empty;
  // R20 keep buffered words
  assign do_push       = bif.push & (~bif.full | do_pop);
  assign bif.overrun_p = bif.push & ~do_push;

  always_comb
  begin
    d = q;
    if (do_push)
    begin
      d.mem[q.wr] = bif.push_word;
      d.wr        = nxt(q.wr);
    end
    if (do_pop)
    begin
      d.rd = nxt(q.rd);
    end
    d.cnt = CW'(q.cnt + CW'(do_push) - CW'(do_pop));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // R20 overrun keeps contents
  property p_ovr_keep;
    @(posedge clk_i) disable iff (rst_i) bif.overrun_p |=> ($stable(q.mem) && q.cnt == CW'(DEPTH));
  endproperty
  a_ovr_keep: assert property (p_ovr_keep) else $error("buffer changed on overrun"); // R20

endmodule : urx_buf

// File: rtl/urx_uart_irq.sv
// UART receive status, error flags, interrupt request and RX wake-up logic.
// Overview of operation
// R01: Parity error flag sets on wrong parity, only with parity enabled.
// R02: Parity error is stored with its word and cleared by reset.
// R03: Interrupt request is a low pulse from six sources.
// R04: Vector taken only with global and module enables set, stack not full.
// R05: Four flagged sources request interrupts through control two enable bits.
// R06: Transmit sources have own enables; receive sources share one enable.
// R07: Address detect raises an interrupt with no flag when enabled.
// R08: Status flags are read-only and survive vector entry.
// R09: With address detect on, receive interrupt needs top received bit high.
// R10: With address detect off, every new received word interrupts.
// R11: Software clears parity enable before enabling address detect.
// R12: With the UART clock off the shift paths pause.
// R13: Idle or sleep leaves status, controls, data and baud untouched.
// R14: Software finishes transfers before entering idle or sleep.
// R15: RX falling edge wakes only with all five enable bits set.
// R16: Words arriving during oscillator start-up are ignored.
// R17: Without global and module enables a wake-up only wakes.
// R18: Wake-up interrupt waits until start-up time has elapsed.
// R19: Data available clears after status access then data read.
// R20: Third word into a full buffer sets overrun, buffer kept.
// R21: All enabled sources merge into one module request.
`timescale 1ns/1ns
module urx_uart_irq #(
  parameter int STARTUP_NS = urx_pkg::STARTUP_NS,
  parameter int RX_DEPTH   = 2
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  output      logic        wb_ack_o,
  // Receiver core.
  input  wire logic        rx_word_valid_i,
  input  wire logic [8:0]  rx_word_i,
  input  wire logic        rx_parity_i,
  input  wire logic        rx_stop_ok_i,
  input  wire logic        rx_idle_i,
  // Transmitter core.
  input  wire logic        tx_empty_i,
  input  wire logic        tx_idle_i,
  // Clock control and processor.
  input  wire logic        uart_clk_on_i,
  input  wire logic        stack_full_i,
  // Pin.
  input  wire logic        rx_i,
  // Controls to the shift paths.
  output      logic [7:0]  baud_o,
  output      logic        nine_bit_o,
  output      logic        parity_enable_o,
  output      logic        parity_odd_o,
  output      logic        rx_run_o,
  output      logic        tx_run_o,
  // Requests.
  output      logic        irq_n_o,
  output      logic        vector_o,
  output      logic        wake_o
);
  localparam int STARTUP_CYC = (STARTUP_NS + urx_pkg::CLK_PERIOD_NS - 1) / urx_pkg::CLK_PERIOD_NS;
  localparam int CNT_W       = 12;

  if (STARTUP_CYC < 10 || STARTUP_CYC >= (1 << CNT_W)) begin : g_chk
    $error("urx_uart_irq start-up count out of range");
  end

  typedef struct packed {
    logic                ack;
    logic [7:0]          rdat;
    logic [7:0]          ctrl1;
    logic [7:0]          ctrl2;
    logic [7:0]          baud;
    logic                gie;
    logic                mie;
    logic                mflag;
    logic                armed;
    logic                ovr;
    logic                txe_p;
    logic                txi_p;
    logic                irq;
    logic                vec;
    logic                wake;
    logic [2:0]          rx_s;
    urx_pkg::urx_wake_t  fsm;
    logic [CNT_W-1:0]    cnt;
  } urx_state_t;

  urx_state_t q;
  urx_state_t d;

  urx_buf_if bif ();

  urx_buf #(
    .DEPTH (RX_DEPTH)
  ) u_buf (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bif   (bif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.
  function automatic logic parity_bad(input logic [8:0] w, input logic nine, input logic odd, input logic pb);
    logic x;
    x          = ^w[7:0] ^ (nine & w[8]) ^ odd;
    parity_bad = (x != pb);
  endfunction : parity_bad

  function automatic logic top_bit(input logic [8:0] w, input logic nine);
    top_bit = nine ? w[8] : w[7];
  endfunction : top_bit

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  logic commit;
  logic wr_commit;
  logic rd_data;
  logic stat_acc;
  logic run;
  logic push_ok;
  logic top;
  logic fall;
  logic ev_txe;
  logic ev_txi;
  logic ev_rxa;
  logic ev_ovr;
  logic ev_adr;
  logic ev_wake;
  logic wake_ev;
  logic ev_any;
  logic vec_take;
  logic [7:0] status;

  assign commit    = wb_cyc_i & wb_stb_i & q.ack;
  assign wr_commit = commit & wb_we_i & wb_sel_i[0];
  assign rd_data   = commit & ~wb_we_i & (wb_adr_i == urx_pkg::ADDR_DATA);
  assign stat_acc  = commit & (wb_adr_i == urx_pkg::ADDR_STATUS);
  assign run       = (q.fsm == urx_pkg::WK_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Receive path into the buffer.
  // R12 pause when clock off
  // R16 ignore start-up words
  assign push_ok            = rx_word_valid_i & uart_clk_on_i & run & q.ctrl2[urx_pkg::C2_RXEN]
                              & q.ctrl1[urx_pkg::C1_UEN] & q.ctrl1[urx_pkg::C1_MODE];
  assign bif.push           = push_ok;
  assign bif.push_word.data = rx_word_i;
  assign bif.push_word.ferr = ~rx_stop_ok_i;
  // R01 parity check gated
  // R02 stored with word
  assign bif.push_word.perr = q.ctrl1[urx_pkg::C1_PEN]
                              & parity_bad(rx_word_i, q.ctrl1[urx_pkg::C1_NINE], q.ctrl1[urx_pkg::C1_ODD],
                                           rx_parity_i);
  // R19 pop after status access
  assign bif.pop            = rd_data & q.armed;
  assign top                = top_bit(rx_word_i, q.ctrl1[urx_pkg::C1_NINE]);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt sources.
  // R05 flagged source enables
  // R06 separate transmit enables
  assign ev_txe  = run & tx_empty_i & q.ctrl2[urx_pkg::C2_TEIE] & ~q.txe_p;
  assign ev_txi  = run & tx_idle_i & q.ctrl2[urx_pkg::C2_TIIE] & ~q.txi_p;
  // R09 address qualifier
  // R10 every word otherwise
  assign ev_rxa  = push_ok & ~bif.overrun_p & q.ctrl2[urx_pkg::C2_RIE] & (~q.ctrl2[urx_pkg::C2_ADEN] | top);
  // R06 shared receive enable
  assign ev_ovr  = bif.overrun_p & q.ctrl2[urx_pkg::C2_RIE];
  // R07 flagless address detect
  assign ev_adr  = push_ok & q.ctrl2[urx_pkg::C2_ADEN] & top;
  // R15 five-bit wake qualifier
  assign fall    = q.rx_s[2] & ~q.rx_s[1];
  assign wake_ev = (q.fsm == urx_pkg::WK_SLEEP) & fall & q.ctrl2[urx_pkg::C2_WAKE] & q.ctrl1[urx_pkg::C1_MODE]
                   & q.ctrl1[urx_pkg::C1_UEN] & q.ctrl2[urx_pkg::C2_RXEN] & q.ctrl2[urx_pkg::C2_RIE];
  // R17 wake without enables
  // R18 interrupt after start-up
  assign ev_wake = (q.fsm == urx_pkg::WK_START) & (q.cnt == CNT_W'(1)) & q.gie & q.mie;
  // R21 merged request
  assign ev_any  = ev_txe | ev_txi | ev_rxa | ev_ovr | ev_adr | ev_wake;
  // R04 vector gating
  assign vec_take = q.mflag & q.gie & q.mie & ~stack_full_i;

  ////////////////////////////////////////////////////////////////////////////
  // Status view.
  always_comb
  begin
    status                    = urx_pkg::RST_BYTE;
    status[urx_pkg::ST_PERR]  = ~bif.empty & bif.head.perr;
    status[urx_pkg::ST_FERR]  = ~bif.empty & bif.head.ferr;
    status[urx_pkg::ST_OVR]   = q.ovr;
    status[urx_pkg::ST_RXA]   = ~bif.empty;
    status[urx_pkg::ST_TXI]   = tx_idle_i;
    status[urx_pkg::ST_TXE]   = tx_empty_i;
    status[urx_pkg::ST_RXI]   = rx_idle_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb
  begin
    d       = q;
    d.ack   = wb_cyc_i & wb_stb_i & ~q.ack;
    d.rx_s  = {q.rx_s[1], q.rx_s[0], rx_i};
    d.txe_p = tx_empty_i & q.ctrl2[urx_pkg::C2_TEIE];
    d.txi_p = tx_idle_i & q.ctrl2[urx_pkg::C2_TIIE];
    // R03 low request pulse
    d.irq   = ev_any;
    d.vec   = vec_take;
    d.wake  = wake_ev;
    // R08 module flag clears on vector entry unless a new event arrives
    d.mflag = ev_any | (q.mflag & ~vec_take);
    if (d.ack)
    begin
      case (wb_adr_i)
        urx_pkg::ADDR_STATUS: d.rdat = status;
        urx_pkg::ADDR_CTRL1:  d.rdat = {q.ctrl1[7:1], bif.head.data[8]};
        urx_pkg::ADDR_CTRL2:  d.rdat = q.ctrl2;
        urx_pkg::ADDR_DATA:   d.rdat = bif.head.data[7:0];
        urx_pkg::ADDR_BAUD:   d.rdat = q.baud;
        urx_pkg::ADDR_INTC:   d.rdat = {5'h00, q.mflag, q.mie, q.gie};
        default:              d.rdat = urx_pkg::RST_BYTE;
      endcase
    end
    // R13 registers hold in sleep
    if (wr_commit)
    begin
      case (wb_adr_i)
        urx_pkg::ADDR_CTRL1: d.ctrl1 = wb_dat_i[7:0] & urx_pkg::C1_WMASK;
        urx_pkg::ADDR_CTRL2: d.ctrl2 = wb_dat_i[7:0];
        urx_pkg::ADDR_BAUD:  d.baud  = wb_dat_i[7:0];
        urx_pkg::ADDR_INTC:
        begin
          d.gie = wb_dat_i[urx_pkg::IC_GIE];
          d.mie = wb_dat_i[urx_pkg::IC_MIE];
        end
        default: d.baud = q.baud;
      endcase
    end
    // R19 status access arms clear
    if (stat_acc)
    begin
      d.armed = 1'b1;
    end
    else if (rd_data)
    begin
      d.armed = 1'b0;
    end
    // R20 overrun flag set wins
    d.ovr = bif.overrun_p | (q.ovr & ~(rd_data & q.armed));
    case (q.fsm)
      urx_pkg::WK_RUN:
      begin
        if (!uart_clk_on_i)
        begin
          d.fsm = urx_pkg::WK_SLEEP;
        end
      end
      urx_pkg::WK_SLEEP:
      begin
        if (wake_ev)
        begin
          d.fsm = urx_pkg::WK_START;
          d.cnt = CNT_W'(STARTUP_CYC);
        end
        else if (uart_clk_on_i)
        begin
          d.fsm = urx_pkg::WK_RUN;
        end
      end
      urx_pkg::WK_START:
      begin
        d.cnt = CNT_W'(q.cnt - 1'b1);
        if (q.cnt == CNT_W'(1))
        begin
          d.fsm = urx_pkg::WK_RUN;
        end
      end
      default: d.fsm = urx_pkg::WK_RUN;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q      <= '0;
      q.rx_s <= urx_pkg::RX_SYNC_IDLE;
      q.fsm  <= urx_pkg::WK_RUN;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign wb_dat_o        = {24'h000000, q.rdat};
  assign wb_ack_o        = q.ack;
  assign baud_o          = q.baud;
  assign nine_bit_o      = q.ctrl1[urx_pkg::C1_NINE];
  assign parity_enable_o = q.ctrl1[urx_pkg::C1_PEN];
  assign parity_odd_o    = q.ctrl1[urx_pkg::C1_ODD];
  // R12 shift paths run only with clock
  assign rx_run_o        = run & q.ctrl2[urx_pkg::C2_RXEN] & q.ctrl1[urx_pkg::C1_UEN] & q.ctrl1[urx_pkg::C1_MODE];
  assign tx_run_o        = run & q.ctrl1[urx_pkg::C1_UEN] & q.ctrl1[urx_pkg::C1_MODE];
  assign irq_n_o         = ~q.irq;
  assign vector_o        = q.vec;
  assign wake_o          = q.wake;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_perr_off;
    @(posedge clk_i) disable iff (rst_i)
      (push_ok && bif.empty && !bif.pop && !q.ctrl1[urx_pkg::C1_PEN]) |=> !bif.head.perr;
  endproperty
  a_perr_off: assert property (p_perr_off) else $error("parity error with parity off"); // R01

  property p_irq_cause;
    @(posedge clk_i) disable iff (rst_i) !irq_n_o |-> $past(ev_any);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request pulse without source"); // R03

  property p_vec_gate;
    @(posedge clk_i) disable iff (rst_i) vector_o |-> $past(q.mflag && q.gie && q.mie && !stack_full_i);
  endproperty
  a_vec_gate: assert property (p_vec_gate) else $error("vector without enables"); // R04

  property p_ovr_hold;
    @(posedge clk_i) disable iff (rst_i) $fell(q.ovr) |-> $past(rd_data && q.armed);
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun cleared without sequence"); // R08

  property p_addr_block;
    @(posedge clk_i) disable iff (rst_i)
      (push_ok && q.ctrl2[urx_pkg::C2_ADEN] && !top && !ev_txe && !ev_txi && !ev_ovr && !ev_wake) |=> irq_n_o;
  endproperty
  a_addr_block: assert property (p_addr_block) else $error("data word interrupted in address mode"); // R09

  property p_rxa_irq;
    @(posedge clk_i) disable iff (rst_i)
      (push_ok && !bif.full && !q.ctrl2[urx_pkg::C2_ADEN] && q.ctrl2[urx_pkg::C2_RIE]) |=> !irq_n_o;
  endproperty
  a_rxa_irq: assert property (p_rxa_irq) else $error("received word without interrupt"); // R10

  property p_wake_qual;
    @(posedge clk_i) disable iff (rst_i)
      wake_o |-> ($past(q.fsm == urx_pkg::WK_SLEEP) && q.fsm == urx_pkg::WK_START && q.ctrl2[urx_pkg::C2_WAKE]);
  endproperty
  a_wake_qual: assert property (p_wake_qual) else $error("wake without qualifier"); // R15

  sequence s_startup;
    wake_o ##1 (q.fsm == urx_pkg::WK_START) [*8];
  endsequence

  property p_start_quiet;
    @(posedge clk_i) disable iff (rst_i) s_startup |-> !bif.push;
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("word taken during start-up"); // R16

  property p_wake_late;
    @(posedge clk_i) disable iff (rst_i) (q.fsm == urx_pkg::WK_START && q.cnt > CNT_W'(1)) |=> irq_n_o;
  endproperty
  a_wake_late: assert property (p_wake_late) else $error("wake interrupt before start-up end"); // R18

  property p_sleep_hold;
    @(posedge clk_i) disable iff (rst_i) (q.fsm == urx_pkg::WK_SLEEP && !wr_commit) |=> $stable(q.baud);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("baud changed in sleep"); // R13

endmodule : urx_uart_irq

// File: verif/urx_far_end.sv
// Far-end transmitter model: RX pin level and finished receive words.
`timescale 1ns/1ns
module urx_far_end (
  // Clock.
  input  wire logic       clk_i,
  // Pin and finished words.
  output      logic       rx_o,
  output      logic       valid_o,
  output      logic [8:0] word_o,
  output      logic       parity_o,
  output      logic       stop_ok_o,
  output      logic       idle_o
);
  initial
  begin
    rx_o      = 1'b1;
    valid_o   = 1'b0;
    word_o    = 9'h155;
    parity_o  = 1'b0;
    stop_ok_o = 1'b1;
    idle_o    = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One finished word; released lines show the inverse afterwards.
  task automatic send(input logic [8:0] d, input logic p);
    @(posedge clk_i);
    valid_o  <= 1'b1;
    word_o   <= d;
    parity_o <= p;
    @(posedge clk_i);
    valid_o  <= 1'b0;
    word_o   <= ~d;
    parity_o <= ~p;
  endtask : send

  // A start bit falling edge on the pin, held well past synchronisation.
  task automatic fall();
    @(posedge clk_i);
    rx_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    rx_o <= 1'b1;
  endtask : fall
endmodule : urx_far_end

// File: verif/test_uart_rx_error_irq_wakeup.sv
// Self-checking bench for the UART status, interrupt and wake-up block.
`timescale 1ns/1ns
module test_uart_rx_error_irq_wakeup;
  localparam logic [7:0] S_PE   = 8'h01 << urx_pkg::ST_PERR;
  localparam logic [7:0] S_OV   = 8'h01 << urx_pkg::ST_OVR;
  localparam logic [7:0] S_RXA  = 8'h01 << urx_pkg::ST_RXA;
  localparam logic [7:0] S_TXE  = 8'h01 << urx_pkg::ST_TXE;
  localparam logic [7:0] S_TXI  = 8'h01 << urx_pkg::ST_TXI;
  localparam logic [7:0] S_IDLE = 8'h01 << urx_pkg::ST_RXI;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        tx_empty = 1'b0;
  logic        clk_on   = 1'b1;
  logic        tx_idle    = 1'b0;
  logic        stack_full = 1'b0;
  logic        rxrun, txrun, nine, pen, podd;
  logic [7:0]  baud;
  logic        rx, vld, par, stp, ridle, irq_n, vec, wake;
  logic [8:0]  word;
  logic [7:0]  irq_cnt  = 8'h00;
  logic [7:0]  vec_cnt  = 8'h00;
  logic [7:0]  wake_cnt = 8'h00;
  logic [7:0]  i0, w0, r;
  int          n_errors = 0;
  int          check_count = 0;

  always #25 clk_i = ~clk_i;

  urx_uart_irq #(.STARTUP_NS(500), .RX_DEPTH(2)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_word_valid_i(vld), .rx_word_i(word), .rx_parity_i(par), .rx_stop_ok_i(stp),
    .rx_idle_i(ridle), .tx_empty_i(tx_empty), .tx_idle_i(tx_idle), .uart_clk_on_i(clk_on),
    .stack_full_i(stack_full), .rx_i(rx), .baud_o(baud), .nine_bit_o(nine), .parity_enable_o(pen),
    .parity_odd_o(podd), .rx_run_o(rxrun), .tx_run_o(txrun), .irq_n_o(irq_n), .vector_o(vec), .wake_o(wake));

  urx_far_end fe_u (.clk_i(clk_i), .rx_o(rx), .valid_o(vld), .word_o(word), .parity_o(par),
    .stop_ok_o(stp), .idle_o(ridle));

  always @(posedge clk_i)
  begin
    if (irq_n === 1'b0) irq_cnt <= irq_cnt + 8'h01;
    if (vec === 1'b1) vec_cnt <= vec_cnt + 8'h01;
    if (wake === 1'b1) wake_cnt <= wake_cnt + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(nm, e, q);
  endtask : rd

  task automatic note(input string s);
    $display("test %s finished", s);
  endtask : note

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  initial
  begin
    #(50 * 3000);
    n_errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(urx_pkg::ADDR_STATUS, S_IDLE, "status reset");
    rd(urx_pkg::ADDR_CTRL1, 8'h00, "ctrl1 reset");
    rd(8'h20, 8'h00, "unmapped read");
    wb(1'b1, urx_pkg::ADDR_INTC, 8'h03, r);
    wb(1'b1, urx_pkg::ADDR_CTRL1, 8'hD0, r);
    wb(1'b1, urx_pkg::ADDR_CTRL2, 8'h4A, r);
    wb(1'b1, urx_pkg::ADDR_BAUD, 8'h5A, r);
    stack_full <= 1'b1;
    tx_empty   <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("tx empty irq", 8'h01, irq_cnt);
    chk("vector blocked", 8'h00, vec_cnt);
    chk("control pins", 8'h1A, {3'h0, rxrun, txrun, nine, pen, podd});
    chk("baud pin", 8'h5A, baud);
    rd(urx_pkg::ADDR_INTC, 8'h07, "request pending");
    stack_full <= 1'b0;
    tx_idle    <= 1'b1;
    rd(urx_pkg::ADDR_STATUS, S_IDLE | S_TXE | S_TXI, "tx flags");
    chk("tx idle masked", 8'h01, irq_cnt);
    wb(1'b1, urx_pkg::ADDR_CTRL2, 8'h46, r);
    repeat (3) @(posedge clk_i);
    chk("tx idle irq", 8'h02, irq_cnt);
    tx_empty <= 1'b0;
    tx_idle  <= 1'b0;
    note("transmit source");
    fe_u.send(9'h001, 1'b0);
    repeat (2) @(posedge clk_i);
    chk("rx irq", 8'h03, irq_cnt);
    rd(urx_pkg::ADDR_STATUS, S_IDLE | S_RXA | S_PE, "parity flag");
    rd(urx_pkg::ADDR_DATA, 8'h01, "parity word");
    rd(urx_pkg::ADDR_STATUS, S_IDLE, "after pop");
    note("parity error");
    fe_u.send(9'h011, 1'b0);
    fe_u.send(9'h022, 1'b0);
    fe_u.send(9'h033, 1'b0);
    rd(urx_pkg::ADDR_STATUS, S_IDLE | S_RXA | S_OV, "overrun");
    wb(1'b1, urx_pkg::ADDR_STATUS, 8'hFF, r);
    rd(urx_pkg::ADDR_STATUS, S_IDLE | S_RXA | S_OV, "status write");
    rd(urx_pkg::ADDR_DATA, 8'h11, "first kept");
    rd(urx_pkg::ADDR_STATUS, S_IDLE | S_RXA, "overrun cleared");
    rd(urx_pkg::ADDR_DATA, 8'h22, "second kept");
    chk("vector seen", 8'h01, {7'h0, vec_cnt != 8'h00});
    note("overrun");
    wb(1'b1, urx_pkg::ADDR_CTRL1, 8'hC0, r);
    wb(1'b1, urx_pkg::ADDR_CTRL2, 8'h62, r);
    i0 = irq_cnt;
    fe_u.send(9'h005, 1'b0);
    repeat (2) @(posedge clk_i);
    chk("data word irq", i0, irq_cnt);
    fe_u.send(9'h085, 1'b0);
    repeat (2) @(posedge clk_i);
    chk("address irq", i0 + 8'h01, irq_cnt);
    rd(urx_pkg::ADDR_STATUS, S_IDLE | S_RXA, "addr status");
    rd(urx_pkg::ADDR_DATA, 8'h05, "data word");
    rd(urx_pkg::ADDR_STATUS, S_IDLE | S_RXA, "addr status 2");
    rd(urx_pkg::ADDR_DATA, 8'h85, "address word");
    wb(1'b1, urx_pkg::ADDR_CTRL1, 8'hE0, r);
    fe_u.send(9'h100, 1'b0);
    repeat (2) @(posedge clk_i);
    chk("ninth bit irq", i0 + 8'h02, irq_cnt);
    rd(urx_pkg::ADDR_CTRL1, 8'hE1, "ninth bit");
    rd(urx_pkg::ADDR_STATUS, S_IDLE | S_RXA, "ninth status");
    rd(urx_pkg::ADDR_DATA, 8'h00, "ninth word");
    wb(1'b1, urx_pkg::ADDR_CTRL1, 8'hC0, r);
    note("address detect");
    wb(1'b1, urx_pkg::ADDR_CTRL2, 8'h52, r);
    clk_on <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("sleep pins", 8'h00, {3'h0, rxrun, txrun, nine, pen, podd});
    i0 = irq_cnt;
    w0 = wake_cnt;
    fe_u.fall();
    @(posedge clk_i);
    chk("wake pulse", w0 + 8'h01, wake_cnt);
    chk("irq held", i0, irq_cnt);
    clk_on <= 1'b1;
    fe_u.send(9'h0AA, 1'b0);
    repeat (20) @(posedge clk_i);
    chk("wake irq", i0 + 8'h01, irq_cnt);
    rd(urx_pkg::ADDR_STATUS, S_IDLE, "startup word");
    rd(urx_pkg::ADDR_CTRL2, 8'h52, "ctrl2 kept");
    rd(urx_pkg::ADDR_CTRL1, 8'hC0, "ctrl1 kept");
    rd(urx_pkg::ADDR_BAUD, 8'h5A, "baud kept");
    note("wake with interrupt");
    wb(1'b1, urx_pkg::ADDR_INTC, 8'h00, r);
    clk_on <= 1'b0;
    repeat (2) @(posedge clk_i);
    fe_u.fall();
    clk_on <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk("wake only", w0 + 8'h02, wake_cnt);
    chk("no wake irq", i0 + 8'h01, irq_cnt);
    note("wake without interrupt");
    conclude();
  end
endmodule : test_uart_rx_error_irq_wakeup
